// [hw/lcce_alu_if.sv]
// Purpose: carries operands and results between the sequencer and the logic unit
// Assumes: purely combinational unit
// Notes: none
`timescale 1ns/1ps
interface lcce_alu_if;
    import lcce_pkg::*;
    lcce_op_e op;
    logic [7:0] accValue;
    logic [7:0] memValue;
    logic [7:0] immValue;
    logic [2:0] bitSel;
    logic [7:0] result;
    logic toAcc;
    logic toMem;
    logic setsZero;
    modport seq (output op, accValue, memValue, immValue, bitSel,
                 input result, toAcc, toMem, setsZero);
    modport unit (input op, accValue, memValue, immValue, bitSel,
                  output result, toAcc, toMem, setsZero);
endinterface

// [hw/lcce_cfg.svh]
// Purpose: constants for the logic, call and clear execution unit
// Assumes: one instruction presented per machine cycle by the decoder
// Notes: a machine cycle is four system clocks
`ifndef LCCE_CFG_SVH
`define LCCE_CFG_SVH
`define LCCE_DATA_W 8
`define LCCE_ADDR_W 8
`define LCCE_PC_W 10
`define LCCE_STACK_DEPTH 2
`define LCCE_CLKS_PER_CYCLE 4
`define LCCE_PHASE_LAST 2'h3
`define LCCE_ZERO_BYTE 8'h00
`define LCCE_ACC_RESET 8'h00
`define LCCE_PC_RESET 10'h000
`define LCCE_PCL_ADDR 8'h06
`endif

// [hw/lcce_exec_unit.sv]
// Purpose: executes AND, call, clear and watchdog clear instructions
// Assumes: decoder holds the instruction until done pulses; memory read data is
//          valid with the request
// Notes: each instruction takes one machine cycle of four clocks, plus one
//        more when it writes the program counter low byte
// Notes on behaviour
// - and of accumulator with memory byte goes to the accumulator
// - and of accumulator with immediate constant goes to the accumulator
// - and of memory with accumulator written back to memory, acc unchanged
// - call pushes program counter plus one onto the return stack
// - call then loads the program counter with the target address
// - clear memory writes zero and leaves all flags alone
// - bit clear zeroes only the chosen bit, others kept
// - writing program counter low byte adds one machine cycle of four clocks
// - watchdog cleared and flags zeroed at once by watchdog clear, by the preclears only after both steps
`timescale 1ns/1ps
`include "lcce_cfg.svh"
module lcce_exec_unit #(
    parameter int PC_W = `LCCE_PC_W,
    parameter int DEPTH = `LCCE_STACK_DEPTH
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction from decoder
    input wire logic instValid,
    input wire lcce_pkg::lcce_op_e instOp,
    input wire logic [7:0] memAddr,
    input wire logic [7:0] immData,
    input wire logic [2:0] bitSel,
    input wire logic [PC_W-1:0] callTarget,
    input wire logic [PC_W-1:0] pcIn,
    input wire logic [7:0] memRdata,
    // accumulator written by instructions outside this unit
    input wire logic accWrite,
    input wire logic [7:0] accWriteData,
    // flags in from status
    input wire logic timeoutFlagIn,
    input wire logic powerdownFlagIn,
    // results
    output logic done,
    output logic [7:0] acc,
    output logic zeroFlag,
    output logic memWe,
    output logic [7:0] memWaddr,
    output logic [7:0] memWdata,
    output logic pcLoad,
    output logic [PC_W-1:0] pcOut,
    output logic [PC_W-1:0] stackTop,
    output logic watchdogClear,
    output logic timeoutFlag,
    output logic powerdownFlag
);
    import lcce_pkg::*;
    lcce_alu_if alu ();
    lcce_logic_unit uLogic (
        .alu(alu)
    );

    lcce_state_e state_reg, state_next;
    logic [1:0] phase_reg, phase_next;
    logic [7:0] acc_reg, acc_next;
    logic zero_reg, zero_next;
    logic memWe_reg, memWe_next;
    logic [7:0] memWaddr_reg, memWaddr_next;
    logic [7:0] memWdata_reg, memWdata_next;
    logic pcLoad_reg, pcLoad_next;
    logic [PC_W-1:0] pcOut_reg, pcOut_next;
    logic [PC_W-1:0] stack_reg [DEPTH];
    logic [PC_W-1:0] stack_next [DEPTH];
    logic done_reg, done_next;
    logic pre1_reg, pre1_next;
    logic pre2_reg, pre2_next;
    logic wdClr_reg, wdClr_next;
    logic to_reg, to_next;
    logic pd_reg, pd_next;
    logic writesPcl;

    assign alu.op = instOp;
    assign alu.accValue = acc_reg;
    assign alu.memValue = memRdata;
    assign alu.immValue = immData;
    assign alu.bitSel = bitSel;
    assign writesPcl = alu.toMem && (memAddr == `LCCE_PCL_ADDR);

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        acc_next = acc_reg;
        zero_next = zero_reg;
        memWe_next = 1'b0;
        memWaddr_next = memWaddr_reg;
        memWdata_next = memWdata_reg;
        pcLoad_next = 1'b0;
        pcOut_next = pcOut_reg;
        stack_next = stack_reg;
        done_next = 1'b0;
        pre1_next = pre1_reg;
        pre2_next = pre2_reg;
        wdClr_next = 1'b0;
        to_next = timeoutFlagIn;
        pd_next = powerdownFlagIn;
        // outside loads only between instructions, so operands stay fixed
        if (accWrite && state_reg == LCCE_ST_IDLE) begin
            acc_next = accWriteData;
        end
        case (state_reg)
            LCCE_ST_IDLE: begin
                if (instValid) begin
                    state_next = LCCE_ST_EXEC;
                    phase_next = 2'h0;
                end
            end
            LCCE_ST_EXEC: begin
                phase_next = phase_reg + 2'h1;
                if (phase_reg == `LCCE_PHASE_LAST) begin
                    if (alu.toAcc) begin
                        acc_next = alu.result;
                    end
                    if (alu.toMem) begin
                        memWe_next = 1'b1;
                        memWaddr_next = memAddr;
                        memWdata_next = alu.result;
                    end
                    if (alu.setsZero) begin
                        zero_next = (alu.result == `LCCE_ZERO_BYTE);
                    end
                    case (instOp)
                        LCCE_OP_CALL: begin
                            stack_next[0] = pcIn + PC_W'(1);
                            for (int i = 1; i < DEPTH; i++) begin
                                stack_next[i] = stack_reg[i-1];
                            end
                            pcLoad_next = 1'b1;
                            pcOut_next = callTarget;
                        end
                        LCCE_OP_WDT_CLR: begin
                            wdClr_next = 1'b1;
                            to_next = 1'b0;
                            pd_next = 1'b0;
                            pre1_next = 1'b0;
                            pre2_next = 1'b0;
                        end
                        LCCE_OP_WDT_PRE1, LCCE_OP_WDT_PRE2: begin
                            if ((instOp == LCCE_OP_WDT_PRE1 && pre2_reg) ||
                                (instOp == LCCE_OP_WDT_PRE2 && pre1_reg)) begin
                                wdClr_next = 1'b1;
                                to_next = 1'b0;
                                pd_next = 1'b0;
                                pre1_next = 1'b0;
                                pre2_next = 1'b0;
                            end else if (instOp == LCCE_OP_WDT_PRE1) begin
                                pre1_next = 1'b1;
                            end else begin
                                pre2_next = 1'b1;
                            end
                        end
                        default: begin
                        end
                    endcase
                    if (writesPcl) begin
                        state_next = LCCE_ST_EXTRA;
                    end else begin
                        state_next = LCCE_ST_IDLE;
                        done_next = 1'b1;
                    end
                end
            end
            LCCE_ST_EXTRA: begin
                phase_next = phase_reg + 2'h1;
                if (phase_reg == `LCCE_PHASE_LAST) begin
                    state_next = LCCE_ST_IDLE;
                    done_next = 1'b1;
                end
            end
            default: begin
                state_next = LCCE_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= LCCE_ST_IDLE;
            phase_reg <= 2'h0;
            acc_reg <= `LCCE_ACC_RESET;
            zero_reg <= 1'b0;
            memWe_reg <= 1'b0;
            memWaddr_reg <= 8'h00;
            memWdata_reg <= 8'h00;
            pcLoad_reg <= 1'b0;
            pcOut_reg <= `LCCE_PC_RESET;
            for (int i = 0; i < DEPTH; i++) begin
                stack_reg[i] <= `LCCE_PC_RESET;
            end
            done_reg <= 1'b0;
            pre1_reg <= 1'b0;
            pre2_reg <= 1'b0;
            wdClr_reg <= 1'b0;
            to_reg <= 1'b0;
            pd_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            memWe_reg <= memWe_next;
            memWaddr_reg <= memWaddr_next;
            memWdata_reg <= memWdata_next;
            pcLoad_reg <= pcLoad_next;
            pcOut_reg <= pcOut_next;
            stack_reg <= stack_next;
            done_reg <= done_next;
            pre1_reg <= pre1_next;
            pre2_reg <= pre2_next;
            wdClr_reg <= wdClr_next;
            to_reg <= to_next;
            pd_reg <= pd_next;
        end
    end

    assign done = done_reg;
    assign acc = acc_reg;
    assign zeroFlag = zero_reg;
    assign memWe = memWe_reg;
    assign memWaddr = memWaddr_reg;
    assign memWdata = memWdata_reg;
    assign pcLoad = pcLoad_reg;
    assign pcOut = pcOut_reg;
    assign stackTop = stack_reg[0];
    assign watchdogClear = wdClr_reg;
    assign timeoutFlag = to_reg;
    assign powerdownFlag = pd_reg;
endmodule

// [hw/lcce_logic_unit.sv]
// Purpose: data path of the AND, clear and complement operations
// Assumes: operands stable while the operation executes
// Notes: combinational only
`timescale 1ns/1ps
`include "lcce_cfg.svh"
module lcce_logic_unit (
    lcce_alu_if.unit alu
);
    import lcce_pkg::*;
    always_comb begin
        alu.result = `LCCE_ZERO_BYTE;
        alu.toAcc = 1'b0;
        alu.toMem = 1'b0;
        alu.setsZero = 1'b0;
        case (alu.op)
            LCCE_OP_AND_ACC: begin
                alu.result = alu.accValue & alu.memValue;
                alu.toAcc = 1'b1;
                alu.setsZero = 1'b1;
            end
            LCCE_OP_AND_IMM: begin
                alu.result = alu.accValue & alu.immValue;
                alu.toAcc = 1'b1;
                alu.setsZero = 1'b1;
            end
            LCCE_OP_AND_MEM: begin
                alu.result = alu.memValue & alu.accValue;
                alu.toMem = 1'b1;
                alu.setsZero = 1'b1;
            end
            LCCE_OP_CLR_MEM: begin
                alu.result = `LCCE_ZERO_BYTE;
                alu.toMem = 1'b1;
            end
            LCCE_OP_CLR_BIT: begin
                alu.result = alu.memValue & ~(8'h01 << alu.bitSel);
                alu.toMem = 1'b1;
            end
            LCCE_OP_CPL_MEM: begin
                alu.result = ~alu.memValue;
                alu.toMem = 1'b1;
                alu.setsZero = 1'b1;
            end
            default: begin
                alu.result = `LCCE_ZERO_BYTE;
            end
        endcase
    end
endmodule

// [hw/lcce_pkg.sv]
// Purpose: types shared by the execution unit files
// Assumes: nothing beyond the constants header
// Notes: operation codes are decoded upstream
package lcce_pkg;
    typedef enum logic [3:0] {
        LCCE_OP_NOP = 4'h0,
        LCCE_OP_AND_ACC = 4'h1,
        LCCE_OP_AND_IMM = 4'h2,
        LCCE_OP_AND_MEM = 4'h3,
        LCCE_OP_CALL = 4'h4,
        LCCE_OP_CLR_MEM = 4'h5,
        LCCE_OP_CLR_BIT = 4'h6,
        LCCE_OP_CPL_MEM = 4'h7,
        LCCE_OP_WDT_CLR = 4'h8,
        LCCE_OP_WDT_PRE1 = 4'h9,
        LCCE_OP_WDT_PRE2 = 4'hA
    } lcce_op_e;
    typedef enum logic [1:0] {
        LCCE_ST_IDLE = 2'b00,
        LCCE_ST_EXEC = 2'b01,
        LCCE_ST_EXTRA = 2'b11
    } lcce_state_e;
endpackage

// [verification/lcce_exec_unit_checker.sv]
// Purpose: port-level checks of the execution unit
// Assumes: decoder holds the instruction and memory data until done
// Notes: flags outputs are compared against the clear pulse only
`timescale 1ns/1ps
module lcce_exec_unit_checker
    import lcce_pkg::*;
#(
    parameter int PC_W = 10,
    parameter int DEPTH = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction side
    input wire logic instValid,
    input wire lcce_pkg::lcce_op_e instOp,
    input wire logic [7:0] memAddr,
    input wire logic [7:0] immData,
    input wire logic [2:0] bitSel,
    input wire logic [PC_W-1:0] callTarget,
    input wire logic [PC_W-1:0] pcIn,
    input wire logic [7:0] memRdata,
    input wire logic accWrite,
    input wire logic [7:0] accWriteData,
    input wire logic timeoutFlagIn,
    input wire logic powerdownFlagIn,
    // result side
    input wire logic done,
    input wire logic [7:0] acc,
    input wire logic zeroFlag,
    input wire logic memWe,
    input wire logic [7:0] memWaddr,
    input wire logic [7:0] memWdata,
    input wire logic pcLoad,
    input wire logic [PC_W-1:0] pcOut,
    input wire logic [PC_W-1:0] stackTop,
    input wire logic watchdogClear,
    input wire logic timeoutFlag,
    input wire logic powerdownFlag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // write lands at the normal slot, completion one machine cycle later
    sequence s_pclWait;
        !done [*4] ##1 done;
    endsequence
    AST_MEM_DONE: assert property (memWe && memWaddr != 8'h06 |-> done)
        else $error("memory write without done");
    AST_PCL_EXTRA: assert property (memWe && memWaddr == 8'h06 |-> s_pclWait)
        else $error("low pc byte write not delayed by four clocks");
    AST_CALL_PUSH: assert property (pcLoad |-> done && stackTop == PC_W'(pcIn + 1))
        else $error("return address wrong");
    AST_CALL_JUMP: assert property (pcLoad |-> pcOut == callTarget)
        else $error("call target wrong");
    AST_AND_MEM: assert property (memWe && instOp == LCCE_OP_AND_MEM |->
        memWdata == (memRdata & acc) && zeroFlag == (memWdata == 8'h00))
        else $error("and into memory wrong");
    AST_CLR_MEM: assert property (memWe && instOp == LCCE_OP_CLR_MEM |->
        memWdata == 8'h00 && $stable(zeroFlag))
        else $error("clear memory wrong");
    AST_CLR_BIT: assert property (memWe && instOp == LCCE_OP_CLR_BIT |->
        memWdata == (memRdata & ~(8'h01 << bitSel)))
        else $error("bit clear wrong");
    AST_AND_ACC: assert property (done && instOp == LCCE_OP_AND_ACC |->
        acc == ($past(acc) & memRdata) && zeroFlag == (acc == 8'h00))
        else $error("and to accumulator wrong");
    AST_AND_IMM: assert property (done && instOp == LCCE_OP_AND_IMM |->
        acc == ($past(acc) & immData) && zeroFlag == (acc == 8'h00))
        else $error("and immediate wrong");
    AST_WDOG: assert property (watchdogClear |-> ##[0:1] (!timeoutFlag && !powerdownFlag))
        else $error("flags not zeroed by watchdog clear");
endmodule

bind lcce_exec_unit lcce_exec_unit_checker #(.PC_W(PC_W), .DEPTH(DEPTH)) i_chk (
    .clk(clk), .rst(rst), .instValid(instValid), .instOp(instOp), .memAddr(memAddr),
    .immData(immData), .bitSel(bitSel), .callTarget(callTarget), .pcIn(pcIn),
    .memRdata(memRdata), .timeoutFlagIn(timeoutFlagIn), .powerdownFlagIn(powerdownFlagIn),
    .accWrite(accWrite), .accWriteData(accWriteData),
    .done(done), .acc(acc), .zeroFlag(zeroFlag), .memWe(memWe), .memWaddr(memWaddr),
    .memWdata(memWdata), .pcLoad(pcLoad), .pcOut(pcOut), .stackTop(stackTop),
    .watchdogClear(watchdogClear), .timeoutFlag(timeoutFlag), .powerdownFlag(powerdownFlag)
);

// [verification/testbench.sv]
// Purpose: self-checking bench of the execution unit
// Assumes: status flags held high so a clear shows
// Notes: cycles are counted from the drive edge to done
`timescale 1ns/1ps
module testbench;
    import lcce_pkg::*;
    typedef struct {
        logic [7:0] acc, wd, wa;
        logic z, we, pl, wc;
        logic [9:0] st, tg;
        int lat;
    } lcce_exp_s;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic instValid = 1'b0;
    lcce_op_e instOp = LCCE_OP_NOP;
    logic [7:0] memAddr = 8'h00, immData = 8'h00, memRdata = 8'h00;
    logic [2:0] bitSel = 3'h0;
    logic [9:0] callTarget = 10'h000, pcIn = 10'h000;
    logic timeoutFlagIn = 1'b1, powerdownFlagIn = 1'b1;
    logic accWrite = 1'b0;
    logic [7:0] accWriteData = 8'h00;
    logic done, zeroFlag, memWe, pcLoad, watchdogClear, timeoutFlag, powerdownFlag;
    logic [7:0] acc, memWaddr, memWdata;
    logic [9:0] pcOut, stackTop;
    lcce_exp_s expQ[$];
    lcce_exp_s e;
    int n_fail = 0, samples_checked = 0, cnt = 0;
    logic sawWe = 1'b0;
    logic [31:0] seed = 32'd52;
    logic [7:0] accM = 8'h00;
    logic zM = 1'b0, pre1 = 1'b0, pre2 = 1'b0;
    lcce_op_e wseq[9] = '{LCCE_OP_WDT_PRE1, LCCE_OP_WDT_PRE1, LCCE_OP_WDT_PRE2,
        LCCE_OP_WDT_PRE2, LCCE_OP_WDT_CLR, LCCE_OP_WDT_PRE2, LCCE_OP_WDT_CLR,
        LCCE_OP_WDT_PRE1, LCCE_OP_WDT_PRE2};

    lcce_exec_unit i_lcce_exec_unit (.clk, .rst, .instValid, .instOp, .memAddr, .immData,
        .bitSel, .callTarget, .pcIn, .memRdata, .accWrite, .accWriteData,
        .timeoutFlagIn, .powerdownFlagIn, .done,
        .acc, .zeroFlag, .memWe, .memWaddr, .memWdata, .pcLoad, .pcOut, .stackTop,
        .watchdogClear, .timeoutFlag, .powerdownFlag);

    always #2 clk = ~clk;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chkVal(input string nm, input logic [9:0] ex, input logic [9:0] got);
        samples_checked++;
        if (got !== ex) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic chkLat(input int ex, input int got);
        samples_checked++;
        if (got != ex) begin
            n_fail++;
            $display("unexpected cycles expected %0d seen %0d", ex, got);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic run(input lcce_op_e op, input logic program_counter_low);
        lcce_exp_s x;
        logic [31:0] r, q, w;
        logic [7:0] a, ld;
        int k;
        r = rnd();
        q = rnd();
        w = rnd();
        ld = w[8] ? w[7:0] : 8'h00;
        accM = ld;
        a = (program_counter_low || q[7:0] != 8'h06) ? (program_counter_low ? 8'h06 : q[7:0]) : 8'h07;
        x = '{acc: accM, wd: 8'h00, wa: a, z: zM, we: 1'b0, pl: 1'b0, wc: 1'b0,
            st: q[17:8] + 10'h001, tg: r[28:19], lat: 5};
        case (op)
            LCCE_OP_AND_ACC: x.acc = accM & r[7:0];
            LCCE_OP_AND_IMM: x.acc = accM & r[15:8];
            LCCE_OP_AND_MEM: x.wd = r[7:0] & accM;
            LCCE_OP_CPL_MEM: x.wd = ~r[7:0];
            LCCE_OP_CLR_BIT: x.wd = r[7:0] & ~(8'h01 << r[18:16]);
            LCCE_OP_CALL: x.pl = 1'b1;
            LCCE_OP_WDT_CLR: x.wc = 1'b1;
            LCCE_OP_WDT_PRE1: x.wc = pre2;
            LCCE_OP_WDT_PRE2: x.wc = pre1;
            default: ;
        endcase
        x.we = op inside {LCCE_OP_AND_MEM, LCCE_OP_CPL_MEM, LCCE_OP_CLR_MEM, LCCE_OP_CLR_BIT};
        if (op inside {LCCE_OP_AND_ACC, LCCE_OP_AND_IMM}) x.z = (x.acc == 8'h00);
        if (op inside {LCCE_OP_AND_MEM, LCCE_OP_CPL_MEM}) x.z = (x.wd == 8'h00);
        if (x.we && program_counter_low) x.lat = 9;
        if (x.wc) {pre1, pre2} = 2'b00;
        else if (op == LCCE_OP_WDT_PRE1) pre1 = 1'b1;
        else if (op == LCCE_OP_WDT_PRE2) pre2 = 1'b1;
        accM = x.acc;
        zM = x.z;
        @(posedge clk);
        accWrite <= 1'b1;
        accWriteData <= ld;
        @(posedge clk);
        accWrite <= 1'b0;
        instValid <= 1'b1;
        instOp <= op;
        memAddr <= a;
        memRdata <= r[7:0];
        immData <= r[15:8];
        bitSel <= r[18:16];
        callTarget <= r[28:19];
        pcIn <= q[17:8];
        expQ.push_back(x);
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (done !== 1'b1 && k < 20);
        instValid <= 1'b0;
        if (k == 20) chkVal("done", 10'h001, 10'(done));
    endtask

    always @(posedge clk) begin
        #1;
        if (memWe === 1'b1) sawWe = 1'b1;
        if (rst) begin
            cnt = 0;
        end else if (done === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            chkLat(e.lat, cnt);
            chkVal("acc", 10'(e.acc), 10'(acc));
            chkVal("zero", 10'(e.z), 10'(zeroFlag));
            chkVal("write", 10'(e.we), 10'(sawWe));
            if (e.we) chkVal("waddr", 10'(e.wa), 10'(memWaddr));
            if (e.we) chkVal("wdata", 10'(e.wd), 10'(memWdata));
            chkVal("pcload", 10'(e.pl), 10'(pcLoad));
            if (e.pl) chkVal("stack", e.st, stackTop);
            if (e.pl) chkVal("target", e.tg, pcOut);
            chkVal("wdclear", 10'(e.wc), 10'(watchdogClear));
            chkVal("flags", e.wc ? 10'h000 : 10'h003, 10'({timeoutFlag, powerdownFlag}));
            sawWe = 1'b0;
            cnt = 0;
        end else if (done === 1'b1) begin
            chkVal("done", 10'h000, 10'h001);
            cnt = 0;
        end else if (instValid) begin
            cnt++;
        end
    end

    initial begin
        #20000;
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 44; i++) run(lcce_op_e'(4'(i % 11)), 1'b0);
        $display("test all operations done");
        for (int i = 7; i > 2; i--) run(lcce_op_e'(4'(i)), 1'b1);
        $display("test low pc byte writes done");
        foreach (wseq[i]) run(wseq[i], 1'b0);
        repeat (2) @(posedge clk);
        $display("test watchdog preclear done");
        give_verdict();
    end
endmodule
